// ### mmam_regs.svh
`ifndef MMAM_REGS_SVH
`define MMAM_REGS_SVH
// Operation
// - multiplexed address mode adds one cycle to both latencies
// - used address bits shrink by one per burst doubling and per width step
// - controller treats data as lost after burst length change; the controller only latches bl_changed, and nothing reads it
// - wait 1024 cycles after dll enable before any read
// - clock change: dll low, wait settle, dll high, wait 1024 before read
// - multiplexed address sent in two parts on consecutive rising edges
// - bank and first part with command, second part next edge
// - refresh carries bank only, may issue back to back in multiplexed mode
// - second cycle maps bits 1,2,6,7,11,12,16,15 onto balls 3,4,8,9,13,14,17,18
// - ball 10 carries bit 19, ball 0 bit 20, width and burst dependent
// - dll, impedance, termination and multiplex fields are one bit each
// - pick latency config matching clock; two top codes reserved
// - mode set: select, write enable, refresh low; opcode on A0-A17
// - no burst 8 with the three configurations that exclude it
`define MMAM_CTRL        12'h000
`define MMAM_ADDR        12'h004
`define MMAM_CMD         12'h008
`define MMAM_STAT        12'h00C
`define MMAM_MODE        12'h010
`define MMAM_CFG_LSB     0
`define MMAM_BL_LSB      3
`define MMAM_MUX_BIT     5
`define MMAM_DLL_BIT     7
`define MMAM_IMP_BIT     8
`define MMAM_ODT_BIT     9
`define MMAM_MODE_RST    18'h0_0000
`define MMAM_DLL_CYC     11'd1024
`define MMAM_SETTLE_CYC  11'd6
`define MMAM_STAT_BUSY   0
`define MMAM_STAT_RDOK   1
`define MMAM_STAT_ERR    2
`endif

// ### mmam_pkg.sv
package mmam_pkg;
    typedef enum logic [2:0] {CMD_NOP, CMD_MODE, CMD_READ, CMD_WRITE, CMD_REF} mmam_cmd_e;
    typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_WAIT} mmam_state_e;
    typedef enum logic [1:0] {BUS_X9, BUS_X18, BUS_X36} mmam_width_e;
endpackage

// ### mmam_addr_map.sv
`timescale 1ns/1ps
`include "mmam_regs.svh"
module mmam_addr_map (
    // address and geometry
    input  wire logic [20:0] addr,
    input  wire logic [1:0]  width,
    input  wire logic [1:0]  bl,
    // ball values
    output logic      [20:0] first_part,
    output logic      [20:0] second_part
);
    // count of used address bits for this width and burst
    function automatic logic [4:0] used_bits(input logic [1:0] w, input logic [1:0] b);
        used_bits = 5'd21 - {3'b000, w} - {3'b000, b};
    endfunction
    logic [4:0]  nbits;
    logic [20:0] masked;
    always_comb
    begin
        nbits = used_bits(width, bl);
        masked = addr & ((21'h1 << nbits) - 21'h1);
        first_part = masked;
        second_part = 21'h0_0000;
        second_part[3] = masked[1];
        second_part[4] = masked[2];
        second_part[8] = masked[6];
        second_part[9] = masked[7];
        second_part[13] = masked[11];
        second_part[14] = masked[12];
        second_part[17] = masked[16];
        second_part[18] = masked[15];
        second_part[10] = masked[19];
        second_part[0] = masked[20];
    end
endmodule

// ### mmam_apb_slave.sv
`timescale 1ns/1ps
`include "mmam_regs.svh"
module mmam_apb_slave (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // register view
    output logic      [31:0] ctrl,
    output logic      [31:0] addr,
    output logic             cmd_go,
    output logic      [2:0]  cmd_code,
    input  wire logic [2:0]  status,
    input  wire logic [17:0] mode
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] addr;
        logic        go;
        logic [2:0]  code;
        logic [31:0] rdata;
        logic        err;
        logic        rdy;
    } mmam_apb_s;
    mmam_apb_s q, d;
    logic acc;
    assign acc = psel & penable;
    always_comb
    begin
        d = q;
        d.go = 1'b0;
        d.err = 1'b0;
        d.rdy = 1'b0;
        if (psel & ~penable)
        begin
            // answer decoded at setup so pready and pslverr leave flip-flops in the access cycle
            d.rdy = 1'b1;
            d.err = ~(paddr inside {`MMAM_CTRL, `MMAM_ADDR, `MMAM_CMD, `MMAM_STAT, `MMAM_MODE});
            case (paddr)
                `MMAM_CTRL: d.rdata = q.ctrl;
                `MMAM_ADDR: d.rdata = q.addr;
                `MMAM_CMD:  d.rdata = {29'h0, q.code};
                `MMAM_STAT: d.rdata = {29'h0, status};
                `MMAM_MODE: d.rdata = {14'h0, mode};
                default:    d.rdata = 32'h0000_0000;
            endcase
        end
        if (acc)
        begin
            if (pwrite)
            begin
                case (paddr)
                    `MMAM_CTRL: d.ctrl = pwdata;
                    `MMAM_ADDR: d.addr = pwdata;
                    `MMAM_CMD:
                    begin
                        d.code = pwdata[2:0];
                        d.go = 1'b1;
                    end
                    default: d.err = d.err;
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end
    // zero wait states: answer in the access cycle
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign prdata = q.rdata;
    assign ctrl = q.ctrl;
    assign addr = q.addr;
    assign cmd_go = q.go;
    assign cmd_code = q.code;
endmodule

// ### mmam_ctrl.sv
`timescale 1ns/1ps
`include "mmam_regs.svh"
module mmam_ctrl (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // memory command pins
    output logic             mem_cs_n,
    output logic             mem_we_n,
    output logic             mem_ref_n,
    output logic      [2:0]  mem_ba,
    output logic      [20:0] mem_addr,
    // read valid flag from the memory
    input  wire logic        read_valid_flag
);
    typedef struct packed {
        mmam_pkg::mmam_state_e st;
        logic        cs_n;
        logic        we_n;
        logic        ref_n;
        logic [2:0]  ba;
        logic [20:0] a;
        logic [20:0] second;
        logic [17:0] mode;
        logic        mux;
        logic [1:0]  blen;
        logic [10:0] wait_cnt;
        logic [10:0] dll_cnt;
        logic        dll_ok;
        logic        err;
        logic        bl_changed;
        logic        vs1;
        logic        vs2;
    } mmam_ctrl_s;
    mmam_ctrl_s q, d;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic        cmd_go;
    logic [2:0]  cmd_code;
    logic [20:0] first_part;
    logic [20:0] second_part;
    logic [2:0]  status;
    logic [17:0] new_mode;
    mmam_apb_slave u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .ctrl     (ctrl),
        .addr     (addr),
        .cmd_go   (cmd_go),
        .cmd_code (cmd_code),
        .status   (status),
        .mode     (q.mode)
    );
    mmam_addr_map u_map (
        .addr        (addr[20:0]),
        .width       (ctrl[21:20]),
        .bl          (q.blen),
        .first_part  (first_part),
        .second_part (second_part)
    );
    // opcode fields from the control register
    always_comb
    begin
        new_mode = 18'h0_0000;
        new_mode[2:0] = ctrl[2:0];
        new_mode[4:3] = ctrl[4:3];
        new_mode[`MMAM_MUX_BIT] = ctrl[5];
        new_mode[`MMAM_DLL_BIT] = ctrl[7];
        new_mode[`MMAM_IMP_BIT] = ctrl[8];
        new_mode[`MMAM_ODT_BIT] = ctrl[9];
    end
    assign status = {q.err, q.dll_ok, q.st != mmam_pkg::ST_IDLE};
    always_comb
    begin
        d = q;
        d.vs1 = read_valid_flag;
        d.vs2 = q.vs1;
        d.cs_n = 1'b1;
        d.we_n = 1'b1;
        d.ref_n = 1'b1;
        if (q.dll_cnt != 11'd0)
            d.dll_cnt = q.dll_cnt - 11'd1;
        else if (q.mode[`MMAM_DLL_BIT])
            d.dll_ok = 1'b1;
        if (q.wait_cnt != 11'd0)
            d.wait_cnt = q.wait_cnt - 11'd1;
        case (q.st)
            mmam_pkg::ST_IDLE:
            begin
                if (cmd_go)
                begin
                    d.err = 1'b0;
                    case (cmd_code)
                        mmam_pkg::CMD_MODE:
                        begin
                            // reserved codes and burst 8 with fast configs refused
                            if (ctrl[2:1] == 2'b11 || ctrl[4:3] == 2'b11 ||
                                (ctrl[4:3] == 2'b10 && (ctrl[2:1] == 2'b00 || ctrl[2:0] == 3'b100)))
                                d.err = 1'b1;
                            else
                            begin
                                d.cs_n = 1'b0;
                                d.we_n = 1'b0;
                                d.ref_n = 1'b0;
                                d.a = {3'b000, new_mode};
                                d.mode = new_mode;
                                d.bl_changed = q.bl_changed | (ctrl[4:3] != q.blen);
                                d.blen = ctrl[4:3];
                                d.mux = ctrl[5];
                                d.dll_ok = 1'b0;
                                d.dll_cnt = ctrl[7] ? `MMAM_DLL_CYC : 11'd0;
                                d.wait_cnt = `MMAM_SETTLE_CYC;
                                d.st = mmam_pkg::ST_WAIT;
                            end
                        end
                        mmam_pkg::CMD_READ, mmam_pkg::CMD_WRITE:
                        begin
                            if (cmd_code == mmam_pkg::CMD_READ && !q.dll_ok)
                                d.err = 1'b1;
                            else
                            begin
                                d.cs_n = 1'b0;
                                d.we_n = (cmd_code == mmam_pkg::CMD_READ);
                                d.ba = addr[26:24];
                                d.a = first_part;
                                d.second = second_part;
                                d.st = q.mux ? mmam_pkg::ST_SECOND : mmam_pkg::ST_IDLE;
                            end
                        end
                        mmam_pkg::CMD_REF:
                        begin
                            d.cs_n = 1'b0;
                            d.ref_n = 1'b0;
                            d.ba = addr[26:24];
                        end
                        default: d.err = 1'b0;
                    endcase
                end
            end
            mmam_pkg::ST_SECOND:
            begin
                d.a = q.second;
                d.st = mmam_pkg::ST_IDLE;
            end
            mmam_pkg::ST_WAIT:
            begin
                if (q.wait_cnt == 11'd0)
                    d.st = mmam_pkg::ST_IDLE;
            end
            default: d.st = mmam_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.cs_n <= 1'b1;
            q.we_n <= 1'b1;
            q.ref_n <= 1'b1;
            q.mode <= `MMAM_MODE_RST;
        end
        else
            q <= d;
    end
    assign mem_cs_n = q.cs_n;
    assign mem_we_n = q.we_n;
    assign mem_ref_n = q.ref_n;
    assign mem_ba = q.ba;
    assign mem_addr = q.a;
endmodule

// ### mmam_ctrl_monitor.sv
`timescale 1ns/1ps
module mmam_ctrl_monitor (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // memory pins
    input  wire logic        mem_cs_n,
    input  wire logic        mem_we_n,
    input  wire logic        mem_ref_n,
    input  wire logic [2:0]  mem_ba,
    input  wire logic [20:0] mem_addr,
    input  wire logic        read_valid_flag
);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    typedef struct packed {
        logic        seen;
        logic [10:0] cnt;
    } mmam_mon_s;
    mmam_mon_s st;
    mmam_mon_s next_st;
    logic      mode_set_command;
    logic      rd;
    logic      mapped;
    assign mode_set_command = !mem_cs_n && !mem_we_n && !mem_ref_n;
    assign rd = !mem_cs_n && mem_we_n && mem_ref_n;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
    // saturating at 1024 keeps the lock counter small
    always_comb
    begin
        next_st = st;
        // a mode set with the dll field low clears seen and restarts the count, so reads stay barred
        if (mode_set_command)
            next_st = '{mem_addr[7], 11'h000};
        else if (st.cnt != 11'h400)
            next_st.cnt = st.cnt + 11'h001;
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    a_cmd_single: assert property (!mem_cs_n |=> mem_cs_n)
        else $error("command held two cycles");
    a_mode_settle: assert property (mode_set_command |=> mem_cs_n [*6])
        else $error("command inside mode settle time");
    a_read_locked: assert property (rd |-> st.seen && st.cnt == 11'h400)
        else $error("read before clock lock");
    a_addr_hold: assert property (!$stable(mem_addr) |-> !mem_cs_n || $past(!mem_cs_n))
        else $error("address moved between commands");
    a_bank_hold: assert property (!$stable(mem_ba) |-> !mem_cs_n)
        else $error("bank moved without command");
    a_opcode_zero: assert property (mode_set_command |-> mem_addr[17:10] == 8'h00)
        else $error("mode opcode high bits set");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr && pready)
        else $error("unmapped access not flagged");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr && pready)
        else $error("mapped access flagged");
    c_mode: cover property (mode_set_command);
    c_read: cover property (rd);
    c_refresh: cover property (!mem_cs_n && mem_we_n && !mem_ref_n);
    c_unmapped: cover property (psel && penable && !mapped);
endmodule

// ### mmam_mem_model.sv
`timescale 1ns/1ps
module mmam_mem_model (
    // command pins
    input  wire logic        clk,
    input  wire logic        cs_n,
    input  wire logic        we_n,
    input  wire logic        ref_n,
    input  wire logic [2:0]  ba,
    input  wire logic [20:0] addr,
    // data valid flag
    output logic             read_valid_flag
);
    logic [17:0] mode = 18'h0_0000;
    logic [20:0] ax;
    logic [20:0] ay;
    logic [2:0]  cmd_ba;
    logic        second = 1'b0;
    logic [31:0] vld = 32'h0000_0000;
    logic [3:0]  rl;
    // write latency is a figure only; no data path is modelled
    logic [3:0]  wl;
    logic        dq_term;
    logic        mask_term;
    int          n_mrs = 0;
    int          n_read = 0;
    int          n_ref = 0;
    always_comb
    begin
        case (mode[2:0])
            3'h2: rl = 4'h6;
            3'h3: rl = 4'h8;
            3'h4: rl = 4'h3;
            3'h5: rl = 4'h5;
            default: rl = 4'h4;
        endcase
        rl = rl + {3'h0, mode[5]};
        wl = rl + 4'h1;
    end
    assign read_valid_flag = vld[0];
    assign dq_term = mode[9] && !vld[0];
    assign mask_term = mode[9];
    always @(posedge clk)
    begin
        vld <= vld >> 1;
        second <= 1'b0;
        if (second)
            ay <= addr;
        // impedance recalibration is internal and never stalls a command
        if (!cs_n && !we_n && !ref_n)
        begin
            mode <= addr[17:0];
            n_mrs <= n_mrs + 1;
        end
        if (!cs_n && ref_n)
        begin
            ax <= addr;
            cmd_ba <= ba;
            second <= mode[5];
        end
        if (!cs_n && we_n && ref_n)
        begin
            n_read <= n_read + 1;
            vld <= (vld >> 1) | (((32'h1 << (32'h1 << mode[4:3])) - 1) << (rl - 4'h1));
        end
        if (!cs_n && we_n && !ref_n)
        begin
            n_ref <= n_ref + 1;
            cmd_ba <= ba;
        end
    end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "mmam_regs.svh"
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, se, mem_cs_n, mem_we_n, mem_ref_n, read_valid_flag;
    logic [2:0]  mem_ba;
    logic [20:0] mem_addr;
    int          errors = 0;
    int          n_compared = 0;
    always #12.5 pclk = ~pclk;
    mmam_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_ref_n(mem_ref_n),
        .mem_ba(mem_ba), .mem_addr(mem_addr), .read_valid_flag(read_valid_flag));
    mmam_mem_model u_mem (.clk(pclk), .cs_n(mem_cs_n), .we_n(mem_we_n), .ref_n(mem_ref_n),
        .ba(mem_ba), .addr(mem_addr), .read_valid_flag(read_valid_flag));
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            rdy = pready;
            rd = prdata;
            se = pslverr;
        end
        while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic issue(input logic [2:0] c);
        apb(1'b1, `MMAM_CMD, {29'h0000_0000, c});
        do
            apb(1'b0, `MMAM_STAT, 32'h0000_0000);
        while (rd[`MMAM_STAT_BUSY] !== 1'b0);
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] cfg, input logic [1:0] bl,
                                        input logic mux, input logic [1:0] w);
        ctl = {10'h000, w, 10'h000, 3'h7, 1'b0, mux, bl, cfg};
    endfunction
    task automatic t_reset;
        check("cs idle", 1, mem_cs_n);
        apb(1'b0, `MMAM_MODE, 32'h0000_0000);
        check("mode reset", 0, rd);
        check("mode err", 0, se);
        apb(1'b0, `MMAM_STAT, 32'h0000_0000);
        check("dll ok reset", 0, rd[`MMAM_STAT_RDOK]);
        apb(1'b0, 12'h014, 32'h0000_0000);
        check("unmapped err", 1, se);
    endtask
    task automatic t_bad_modes;
        int m;
        logic [31:0] bad [4];
        m = u_mem.n_mrs;
        bad = '{ctl(3'h6, 2'h0, 1'b0, 2'h0), ctl(3'h7, 2'h0, 1'b0, 2'h0),
                ctl(3'h0, 2'h2, 1'b0, 2'h0), ctl(3'h2, 2'h3, 1'b0, 2'h0)};
        foreach (bad[i])
        begin
            apb(1'b1, `MMAM_CTRL, bad[i]);
            issue(3'h1);
            check("mode set count", m, u_mem.n_mrs);
            apb(1'b0, `MMAM_STAT, 32'h0000_0000);
            check("err flag", 1, rd[`MMAM_STAT_ERR]);
        end
    endtask
    task automatic t_dll_lock;
        int r;
        apb(1'b1, `MMAM_CTRL, ctl(3'h2, 2'h1, 1'b0, 2'h0));
        issue(3'h1);
        check("opcode", ctl(3'h2, 2'h1, 1'b0, 2'h0) & 32'h0003_FFFF, u_mem.mode);
        r = u_mem.n_read;
        issue(3'h2);
        check("early read", r, u_mem.n_read);
        repeat (1024) @(posedge pclk);
        issue(3'h2);
        check("locked read", r + 1, u_mem.n_read);
        apb(1'b0, `MMAM_STAT, 32'h0000_0000);
        check("dll ok", 1, rd[`MMAM_STAT_RDOK]);
    endtask
    task automatic t_mux_read;
        logic [20:0] a;
        logic [20:0] e;
        a = 21'h15_A5C3;
        e = {2'h0, a[15], a[16], 2'h0, a[12], a[11], 2'h0, a[19], a[7], a[6], 3'h0,
             a[2], a[1], 2'h0, a[20]};
        apb(1'b1, `MMAM_CTRL, ctl(3'h2, 2'h0, 1'b1, 2'h0));
        issue(3'h1);
        repeat (1024) @(posedge pclk);
        apb(1'b1, `MMAM_ADDR, {5'h00, 3'h5, 3'h0, a});
        issue(3'h2);
        check("first part", a & 21'h06_6739, u_mem.ax & 21'h06_6739);
        check("second part", e, u_mem.ay & 21'h06_6719);
        check("read bank", 5, u_mem.cmd_ba);
        check("read latency", 7, u_mem.rl);
        check("write latency", 8, u_mem.wl);
        apb(1'b1, `MMAM_CTRL, ctl(3'h2, 2'h0, 1'b1, 2'h1));
        apb(1'b1, `MMAM_ADDR, {5'h00, 3'h3, 3'h0, ~a});
        issue(3'h3);
        check("write first part", ~a & 21'h06_6739, u_mem.ax & 21'h06_6739);
        check("write second part", ~e & 21'h06_6718, u_mem.ay & 21'h06_6718);
        check("write bank", 3, u_mem.cmd_ba);
    endtask
    task automatic t_refresh;
        int r;
        r = u_mem.n_ref;
        apb(1'b1, `MMAM_ADDR, 32'h0200_0000);
        issue(3'h4);
        issue(3'h4);
        check("refresh count", r + 2, u_mem.n_ref);
        check("refresh bank", 2, u_mem.cmd_ba);
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_bad_modes;
        t_dll_lock;
        t_mux_read;
        t_refresh;
        complete_run;
    end
    initial
    begin
        repeat (6000) @(posedge pclk);
        errors++;
        complete_run;
    end
endmodule
bind mmam_ctrl mmam_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
    .mem_ref_n(mem_ref_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
    .read_valid_flag(read_valid_flag));
